// >>> logic/prom_host_pkg.sv
`default_nettype none
package prom_host_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam logic [14:0] LAST_ADDR = 15'h7fff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int PULSE_US = 100;
  localparam int PULSE_CYC = (PULSE_US * 1000) / CLK_PERIOD_NS;
  localparam int ACCESS_NS = 250;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_NS = 30;
  localparam int FLOAT_CYC = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_PULSES = 25;

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_READ = 3'h0;
  localparam logic [2:0] CMD_PROG = 3'h1;
  localparam logic [2:0] CMD_IDENT = 3'h2;
  localparam logic [2:0] CMD_FINAL = 3'h3;

  // Pin levels driven toward the memory
  typedef struct packed {
    logic        chip_sel_n;
    logic        out_gate_n;
    logic        prog_supply_hi;
    logic        core_supply_hi;
    logic        id_high_voltage_level;
    logic [14:0] addr;
  } pin_ctl_t;

  typedef struct packed {
    logic [2:0]  cmd;
    logic [14:0] addr;
    logic [7:0]  data;
  } req_t;

endpackage
`default_nettype wire

// >>> logic/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 8
) (
  input  wire logic         CLK,
  input  wire logic         SYS_RST,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ----------------------------------------------------------------
  // Three stages; a bit moves only when stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          q[i] <= 1'b0;
        end else if (s2[i] == s3[i]) begin
          q[i] <= s3[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// >>> logic/prom_host.sv
`timescale 1ns/1ns
`default_nettype none
module prom_host #(
  parameter int PULSE_CYC  = prom_host_pkg::PULSE_CYC,
  parameter int MAX_PULSES = prom_host_pkg::MAX_PULSES
) (
  input  wire logic                 CLK,
  input  wire logic                 SYS_RST,
  input  wire prom_host_pkg::req_t  REQ,
  input  wire logic                 REQ_VALID,
  output logic                      REQ_READY,
  output logic [7:0]                RSP_DATA,
  output logic                      RSP_VALID,
  output logic                      RSP_FAIL,
  output var prom_host_pkg::pin_ctl_t PIN_CTL,
  output logic [7:0]                DATA_PINS_O,
  output logic                      DATA_PINS_OE,
  input  wire logic [7:0]           DATA_PINS_I
);
  typedef enum logic [7:0] {
    IDLE   = 8'h01,
    SETUP  = 8'h02,
    PULSE  = 8'h04,
    GAP    = 8'h08,
    VERIFY = 8'h10,
    SAMPLE = 8'h20,
    FLOAT  = 8'h40,
    DONE   = 8'h80
  } state_t;

  state_t              state;
  prom_host_pkg::req_t cur;
  logic [16:0]         cnt;
  logic [7:0]          pulses;
  logic [7:0]          pins_sync;
  logic                mismatch;
  logic                fail;

  pin_sync #(.W(8)) u_sync (
    .CLK     (CLK),
    .SYS_RST (SYS_RST),
    .d       (DATA_PINS_I),
    .q       (pins_sync)
  );

  assign REQ_READY = (state == IDLE);
  // The synchroniser adds latency, so the verify sample waits for it
  assign mismatch = (cur.cmd == prom_host_pkg::CMD_READ) ? 1'b0
                  : (cur.cmd == prom_host_pkg::CMD_IDENT) ? ~(^pins_sync)
                  : (pins_sync != cur.data);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state  <= IDLE;
      cur    <= '0;
      cnt    <= '0;
      pulses <= '0;
      fail   <= 1'b0;
    end else begin
      unique case (state)
        IDLE: begin
          if (REQ_VALID) begin
            cur    <= REQ;
            pulses <= '0;
            fail   <= 1'b0;
            cnt    <= 17'(prom_host_pkg::ACCESS_CYC);
            state  <= (REQ.cmd == prom_host_pkg::CMD_PROG) ? SETUP : VERIFY;
          end
        end
        SETUP: begin
          cnt   <= 17'(PULSE_CYC);
          state <= PULSE;
        end
        PULSE: begin
          if (cnt == 17'h00001) begin
            cnt   <= 17'(prom_host_pkg::FLOAT_CYC);
            state <= GAP;
          end else begin
            cnt <= cnt - 17'h00001;
          end
        end
        GAP: begin
          if (cnt == 17'h00001) begin
            pulses <= pulses + 8'h01;
            cnt    <= 17'(prom_host_pkg::ACCESS_CYC);
            state  <= VERIFY;
          end else begin
            cnt <= cnt - 17'h00001;
          end
        end
        VERIFY: begin
          if (cnt == 17'h00001) begin
            cnt   <= 17'h00004;
            state <= SAMPLE;
          end else begin
            cnt <= cnt - 17'h00001;
          end
        end
        SAMPLE: begin
          if (cnt == 17'h00001) begin
            cnt <= 17'(prom_host_pkg::FLOAT_CYC);
            if (cur.cmd == prom_host_pkg::CMD_PROG && mismatch &&
                pulses < 8'(MAX_PULSES)) begin
              state <= SETUP;
            end else begin
              fail  <= mismatch;
              state <= FLOAT;
            end
          end else begin
            cnt <= cnt - 17'h00001;
          end
        end
        FLOAT: begin
          if (cnt == 17'h00001) begin
            state <= DONE;
          end else begin
            cnt <= cnt - 17'h00001;
          end
        end
        DONE: begin
          state <= IDLE;
        end
        default: begin
          state <= IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Answer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      RSP_DATA  <= '0;
      RSP_VALID <= 1'b0;
      RSP_FAIL  <= 1'b0;
    end else begin
      RSP_VALID <= (state == DONE);
      RSP_FAIL  <= (state == DONE) && fail;
      if (state == SAMPLE && cnt == 17'h00001) begin
        RSP_DATA <= pins_sync;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PIN_CTL      <= '{chip_sel_n: 1'b1, out_gate_n: 1'b1, prog_supply_hi: 1'b0,
                        core_supply_hi: 1'b0, id_high_voltage_level: 1'b0, addr: '0};
      DATA_PINS_O  <= prom_host_pkg::ERASED_BYTE;
      DATA_PINS_OE <= 1'b0;
    end else begin
      PIN_CTL.addr                  <= cur.addr;
      // Identifier readout: all other address lines low
      if (cur.cmd == prom_host_pkg::CMD_IDENT) begin
        PIN_CTL.addr <= {14'h0000, cur.addr[0]};
      end
      PIN_CTL.prog_supply_hi        <= (cur.cmd == prom_host_pkg::CMD_PROG) &&
                                       (state != IDLE);
      PIN_CTL.core_supply_hi        <= (cur.cmd == prom_host_pkg::CMD_PROG) &&
                                       (state != IDLE);
      PIN_CTL.id_high_voltage_level <= (cur.cmd == prom_host_pkg::CMD_IDENT) &&
                                       (state != IDLE);
      // Program: chip select pulses low, gate high, data driven
      PIN_CTL.chip_sel_n  <= !((state == PULSE) ||
                               ((state == VERIFY || state == SAMPLE) &&
                                cur.cmd != prom_host_pkg::CMD_PROG));
      PIN_CTL.out_gate_n  <= !(state == VERIFY || state == SAMPLE);
      DATA_PINS_O         <= cur.data;
      DATA_PINS_OE        <= (state == SETUP || state == PULSE);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_no_bus_fight: assert property (@(posedge CLK) disable iff (SYS_RST)
    DATA_PINS_OE |-> PIN_CTL.out_gate_n) else $error("host drives while gate low");
  a_prog_entry: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!PIN_CTL.chip_sel_n && PIN_CTL.out_gate_n) |-> PIN_CTL.prog_supply_hi)
    else $error("chip select low with gate high off supply");
  a_verify_levels: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!PIN_CTL.out_gate_n && PIN_CTL.prog_supply_hi) |-> PIN_CTL.chip_sel_n)
    else $error("verify without chip select high");
  a_ident_addr: assert property (@(posedge CLK) disable iff (SYS_RST)
    PIN_CTL.id_high_voltage_level |-> (PIN_CTL.addr[14:1] == 14'h0000))
    else $error("identifier address lines not low");
  a_core_raise: assert property (@(posedge CLK) disable iff (SYS_RST)
    $rose(DATA_PINS_OE) |-> PIN_CTL.core_supply_hi) else $error("pulse at nominal core");
  a_pulse_len: assert property (@(posedge CLK) disable iff (SYS_RST)
    $fell(PIN_CTL.chip_sel_n) && PIN_CTL.prog_supply_hi |->
    !PIN_CTL.chip_sel_n [*8]) else $error("program pulse too short");
  a_data_setup: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!PIN_CTL.chip_sel_n && PIN_CTL.prog_supply_hi) |-> DATA_PINS_OE)
    else $error("pulse without data driven");
  a_one_answer: assert property (@(posedge CLK) disable iff (SYS_RST)
    RSP_VALID |=> !RSP_VALID) else $error("answer longer than one cycle");
  c_prog: cover property (@(posedge CLK) disable iff (SYS_RST)
    RSP_VALID && cur.cmd == prom_host_pkg::CMD_PROG);
  c_retry: cover property (@(posedge CLK) disable iff (SYS_RST) pulses == 8'h02);
  c_ident: cover property (@(posedge CLK) disable iff (SYS_RST)
    RSP_VALID && cur.cmd == prom_host_pkg::CMD_IDENT);
endmodule
`default_nettype wire

// >>> dv/prom_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Memory device seen from its pins
// ----
module prom_model #(
  parameter int         DLY_NS = 40,
  parameter logic [7:0] MK     = 8'h8a, // Arbitrary value, odd parity
  parameter logic [7:0] DV     = 8'h2c  // Arbitrary value, odd parity
) (
  input  wire prom_host_pkg::pin_ctl_t pin_ctl,
  input  wire logic [7:0]              host_o,
  input  wire logic                    host_oe,
  output logic [7:0]                   pins
);
  logic [7:0] mem [0:32767];
  logic [7:0] dout;
  logic [7:0] held = 8'h5a;
  logic       rd_mode;
  logic       vfy_mode;
  logic       drive;
  logic       cs_n;
  initial for (int i = 0; i < 32768; i++) mem[i] = 8'hff;
  assign cs_n = pin_ctl.chip_sel_n;
  assign rd_mode = !cs_n && !pin_ctl.out_gate_n && !pin_ctl.prog_supply_hi;
  assign vfy_mode = cs_n && !pin_ctl.out_gate_n && pin_ctl.prog_supply_hi;
  // Turn-on and float both lag, so a host sampling too early sees junk
  assign #(DLY_NS) drive = rd_mode || vfy_mode;
  assign dout = (rd_mode && pin_ctl.id_high_voltage_level) ?
                (pin_ctl.addr[0] ? DV : MK) : mem[pin_ctl.addr];
  // Released pins show the inverse of the last level, not a stale copy
  assign pins = host_oe ? host_o : (drive ? dout : held);
  always @(pins) if (host_oe || drive) held = ~pins;
  always @(negedge cs_n) begin
    if (pin_ctl.prog_supply_hi && pin_ctl.out_gate_n && host_oe) begin
      mem[pin_ctl.addr] = mem[pin_ctl.addr] & pins;
    end
  end
endmodule
`default_nettype wire

// >>> dv/prom_host_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
// ----
// Bench for the memory host
// ----
module prom_host_tb_top;
  localparam int         PC = 10;
  localparam int         MP = 3;
  localparam logic [7:0] MK = 8'h8a; // Arbitrary value, odd parity
  localparam logic [7:0] DV = 8'h2c; // Arbitrary value, odd parity
  logic                    CLK = 0;
  logic                    SYS_RST = 1;
  prom_host_pkg::req_t     req = '0;
  logic                    req_valid = 0;
  logic                    req_ready, rsp_valid, rsp_fail, pins_oe;
  logic [7:0]              rsp_data, pins_o, pins_i, d, d2;
  prom_host_pkg::pin_ctl_t pc;
  int                      num_errors = 0;
  int                      cmp_count = 0;
  int                      seed = 10843;
  int                      plen = 0;
  int                      n;
  logic [8:0]              expq [$];
  logic [8:0]              e;
  logic [14:0]             a;
  prom_host #(.PULSE_CYC(PC), .MAX_PULSES(MP)) dut_u (.CLK(CLK), .SYS_RST(SYS_RST),
    .REQ(req), .REQ_VALID(req_valid), .REQ_READY(req_ready), .RSP_DATA(rsp_data),
    .RSP_VALID(rsp_valid), .RSP_FAIL(rsp_fail), .PIN_CTL(pc), .DATA_PINS_O(pins_o),
    .DATA_PINS_OE(pins_oe), .DATA_PINS_I(pins_i));
  prom_model #(.DLY_NS(40), .MK(MK), .DV(DV)) mdl_u (.pin_ctl(pc), .host_o(pins_o),
    .host_oe(pins_oe), .pins(pins_i));
  initial forever #50 CLK = ~CLK;
  task automatic end_of_test;
    $display("Errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic send(input logic [2:0] cmd, input logic [14:0] ad, input logic [7:0] dt,
                      input logic [8:0] ex);
    int k;
    k = 0;
    @(posedge CLK);
    #1;
    req = '{cmd: cmd, addr: ad, data: dt};
    req_valid = 1;
    while (req_ready !== 1'b1 && k < 5000) begin
      @(posedge CLK);
      #1;
      k++;
    end
    if (k == 5000) begin
      num_errors++;
      end_of_test();
    end
    expq.push_back(ex);
    @(posedge CLK);
    #1;
    req_valid = 0;
    `CHK("busy ready", req_ready, 1'b0)
  endtask
  // Settled outputs are sampled half a cycle after the launching edge
  always @(negedge CLK) begin
    if (rsp_valid === 1'b1) begin
      `CHK("queue", expq.size() > 0, 1'b1)
      e = expq.pop_front();
      `CHK("rsp data", rsp_data, e[7:0])
      `CHK("rsp fail", rsp_fail, e[8])
    end
    if (pc.chip_sel_n === 1'b0 && pc.prog_supply_hi === 1'b1) begin
      plen++;
      `CHK("prog pins", {pc.out_gate_n, pins_oe, pc.core_supply_hi}, 3'b111)
    end else if (plen != 0) begin
      `CHK("pulse len", plen, PC)
      plen = 0;
    end
    if (pins_oe === 1'b1) `CHK("contention", pc.out_gate_n, 1'b1)
    if (pc.chip_sel_n === 1'b0 && pc.out_gate_n === 1'b0)
      `CHK("read supplies", {pc.prog_supply_hi, pc.core_supply_hi}, 2'b00)
    if (pc.id_high_voltage_level === 1'b1 && pc.out_gate_n === 1'b0)
      `CHK("id addr", pc.addr[14:1], 14'h0)
  end
  initial begin
    #10_000_000;
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge CLK);
    #1;
    SYS_RST = 0;
    for (int i = 0; i < 4; i++) begin
      // Low bits from the loop index keep the random addresses distinct
      a = {13'($random(seed)), 2'(i)};
      d = 8'($random(seed));
      d2 = ~d;
      send(prom_host_pkg::CMD_READ, a, 8'h00, {1'b0, prom_host_pkg::ERASED_BYTE});
      send(prom_host_pkg::CMD_PROG, a, d, {1'b0, d});
      send(prom_host_pkg::CMD_FINAL, a, d, {1'b0, d});
      send(prom_host_pkg::CMD_PROG, a, d2, {|(~d & d2), d & d2});
      send(prom_host_pkg::CMD_FINAL, a, d2, {|d2, d & d2});
    end
    send(prom_host_pkg::CMD_IDENT, 15'h0000, 8'h00, {1'b0, MK});
    send(prom_host_pkg::CMD_IDENT, 15'h0001, 8'h00, {1'b0, DV});
    n = 0;
    while (expq.size() > 0 && n < 5000) begin
      @(posedge CLK);
      n++;
    end
    if (n == 5000) num_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
